// ---- pkg/mmr_pkg.sv ----
// Contract
// - peripheral-bus and system-bus peripheral areas are 2 MB windows of 128 slots
// - each peripheral slot spans 16 KB; slot index comes from bits above 16 KB
// - peripheral registers are word aligned; no byte-lane steering is provided
// - eight exception vector words sit at 0x00 through 0x1C, fast interrupt last
// - any reset forces boot-loader mapping, boot block vectors at address zero
// - user-flash mode leaves the low area unmapped, served from flash bottom
// - user-RAM mode serves the low area from the bottom of on-chip SRAM
// - user-external mode needs boot pins not 11 at reset end; serves external bottom
// - the overlay covers 64 bytes, addresses 0x00 through 0x3F
// - re-mapped sources stay reachable at their own natural addresses too
// - the whole boot block decodes at the top of on-chip memory space
// - everything outside the overlay stays at fixed addresses in every mode
// - the reserved vector word at 0x14 maps like any other overlay word
// - the active mapping mode is held in a software-writable control setting
// - data accesses and fetches to unassigned regions get a bus abort
// - any fetch into either peripheral area gets a prefetch abort
package mmr_pkg;

  typedef enum logic [1:0] {
    MMR_MODE_BOOT,
    MMR_MODE_FLASH,
    MMR_MODE_RAM,
    MMR_MODE_EXT
  } mmr_mode_t;

  typedef enum logic [2:0] {
    MMR_TGT_NONE,
    MMR_TGT_FLASH,
    MMR_TGT_SRAM,
    MMR_TGT_BOOT,
    MMR_TGT_EXT,
    MMR_TGT_SYS_PERIPH,
    MMR_TGT_PERIPH_BUS
  } mmr_target_t;

  // vector table and overlay
  localparam logic [31:0] MMR_VEC_RESET      = 32'h0000_0000;
  localparam logic [31:0] MMR_VEC_RESERVED   = 32'h0000_0014;
  localparam logic [31:0] MMR_VEC_IRQ        = 32'h0000_0018;
  localparam logic [31:0] MMR_VEC_FAST_INT   = 32'h0000_001C;
  localparam logic [31:0] MMR_OVERLAY_LAST   = 32'h0000_003F;
  localparam int          MMR_OVERLAY_BITS   = 6;

  // fixed memory regions
  localparam logic [31:0] MMR_FLASH_BASE     = 32'h0000_0000;
  localparam logic [31:0] MMR_SRAM_BASE      = 32'h4000_0000;
  localparam logic [31:0] MMR_BOOT_BASE      = 32'h7FFF_E000;
  localparam logic [31:0] MMR_ONCHIP_LAST    = 32'h7FFF_FFFF;
  localparam logic [31:0] MMR_EXT_BASE       = 32'h8000_0000;
  localparam logic [31:0] MMR_EXT_LAST       = 32'h83FF_FFFF;

  // peripheral areas: 2 MB windows, 16 KB slots
  localparam int          MMR_AREA_LSB       = 21;
  localparam int          MMR_SLOT_LSB       = 14;
  localparam int          MMR_SLOT_BITS      = 7;
  localparam int          MMR_SLOT_COUNT     = 128;
  localparam logic [10:0] MMR_PERIPH_BUS_TAG = 11'h700;
  localparam logic [10:0] MMR_SYS_PERIPH_TAG = 11'h7FF;

  // boot strap
  localparam logic [1:0]  MMR_STRAP_INTERNAL = 2'h3;
  localparam logic [1:0]  MMR_STRAP_DELAY    = 2'h2;

endpackage

// ---- core/mmr_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module mmr_decoder #(
  parameter logic [31:0]  FLASH_BYTES      = 32'h0002_0000,
  parameter logic [31:0]  SRAM_BYTES       = 32'h0000_4000,
  parameter bit           EXT_PRESENT      = 1'b1,
  parameter logic [127:0] PERIPH_BUS_SLOTS = 128'h8000_0000_0000_0000_0000_0000_0000_3F7F,
  parameter logic [127:0] SYS_PERIPH_SLOTS = 128'h8000_0000_0000_0000_0000_0000_0000_0001
) (
  // clock and reset
  input  wire  logic                    ref_clk_i,
  input  wire  logic                    rst_n_i,
  // boot strap pins
  input  wire  logic [1:0]              boot_select_pins_i,
  // mapping control setting
  input  wire  logic                    map_wr_i,
  input  wire  mmr_pkg::mmr_mode_t      map_mode_i,
  // bus request from the core
  input  wire  logic                    req_valid_i,
  input  wire  logic [31:0]             req_addr_i,
  input  wire  logic                    req_fetch_i,
  // decoded response
  output logic                          resp_valid_o,
  output mmr_pkg::mmr_target_t          resp_target_o,
  output logic [31:0]                   resp_addr_o,
  output logic [6:0]                    resp_slot_o,
  output logic                          abort_o,
  output logic                          prefetch_abort_o,
  // status
  output mmr_pkg::mmr_mode_t            map_mode_o,
  output logic                          strap_ext_o
);
  import mmr_pkg::*;

  if (FLASH_BYTES == 32'h0 || FLASH_BYTES > MMR_SRAM_BASE) begin : g_bad_flash
    $error("flash size does not fit the on-chip area");
  end
  if (SRAM_BYTES == 32'h0 || SRAM_BYTES > (MMR_BOOT_BASE - MMR_SRAM_BASE)) begin : g_bad_sram
    $error("sram size does not fit below the boot block");
  end

  // boot pin synchroniser and strap capture
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] strap_cnt;
  logic [1:0] next_strap_cnt;
  logic       strap_ext;
  logic       next_strap_ext;
  mmr_mode_t  mode;
  mmr_mode_t  next_mode;

  always_ff @(posedge ref_clk_i) begin
    pin_meta <= boot_select_pins_i;
    pin_sync <= pin_meta;
  end

  always_comb begin
    next_strap_cnt = strap_cnt;
    next_strap_ext = strap_ext;
    next_mode      = mode;
    // wait for the sync chain to hold post-reset pin levels
    if (strap_cnt != MMR_STRAP_DELAY) begin
      next_strap_cnt = strap_cnt + 2'h1;
    end else if (strap_cnt == MMR_STRAP_DELAY - 2'h1) begin
      next_strap_cnt = strap_cnt;
    end
    if (strap_cnt == MMR_STRAP_DELAY - 2'h1) begin
      next_strap_ext = (pin_sync != MMR_STRAP_INTERNAL);
    end
    if (map_wr_i) begin
      // external mode is refused when the pins strapped for internal boot
      if (map_mode_i != MMR_MODE_EXT || next_strap_ext) begin
        next_mode = map_mode_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      strap_cnt <= 2'h0;
      strap_ext <= 1'b0;
      mode      <= MMR_MODE_BOOT;
    end else begin
      strap_cnt <= next_strap_cnt;
      strap_ext <= next_strap_ext;
      mode      <= next_mode;
    end
  end

  // address decode, one registered stage
  logic        next_valid;
  mmr_target_t next_target;
  logic [31:0] next_addr;
  logic [6:0]  next_slot;
  logic        next_abort;
  logic        next_pabort;
  logic [31:0] phys;
  logic [31:0] low_off;
  logic [10:0] area_tag;
  logic        is_periph;

  always_comb begin
    low_off = {26'h0, req_addr_i[MMR_OVERLAY_BITS-1:0]};
    phys    = req_addr_i;
    // decode uses the registered mode, so a write lands whole after it completes
    if (req_addr_i <= MMR_OVERLAY_LAST) begin
      unique case (mode)
        MMR_MODE_BOOT:  phys = MMR_BOOT_BASE | low_off;
        MMR_MODE_FLASH: phys = MMR_FLASH_BASE | low_off;
        MMR_MODE_RAM:   phys = MMR_SRAM_BASE | low_off;
        MMR_MODE_EXT:   phys = MMR_EXT_BASE | low_off;
      endcase
    end
    // every other address passes untranslated
    area_tag    = phys[31:MMR_AREA_LSB];
    next_slot   = 7'h0;
    next_target = MMR_TGT_NONE;
    is_periph   = 1'b0;
    // natural addresses decode the same whatever the mode
    if (phys < MMR_FLASH_BASE + FLASH_BYTES) begin
      next_target = MMR_TGT_FLASH;
    end else if (phys >= MMR_SRAM_BASE && phys < MMR_SRAM_BASE + SRAM_BYTES) begin
      next_target = MMR_TGT_SRAM;
    end else if (phys >= MMR_BOOT_BASE && phys <= MMR_ONCHIP_LAST) begin
      next_target = MMR_TGT_BOOT;
    end else if (EXT_PRESENT && phys >= MMR_EXT_BASE && phys <= MMR_EXT_LAST) begin
      next_target = MMR_TGT_EXT;
    end else if (area_tag == MMR_PERIPH_BUS_TAG || area_tag == MMR_SYS_PERIPH_TAG) begin
      is_periph = 1'b1;
      next_slot = phys[MMR_SLOT_LSB+MMR_SLOT_BITS-1:MMR_SLOT_LSB];
      if (area_tag == MMR_PERIPH_BUS_TAG && PERIPH_BUS_SLOTS[next_slot]) begin
        next_target = MMR_TGT_PERIPH_BUS;
      end else if (area_tag == MMR_SYS_PERIPH_TAG && SYS_PERIPH_SLOTS[next_slot]) begin
        next_target = MMR_TGT_SYS_PERIPH;
      end
    end
    // word address only: no lane steering, sub-word peripheral access is the master's duty
    next_addr   = (is_periph) ? {phys[31:2], 2'h0} : phys;
    next_valid  = req_valid_i;
    next_abort  = req_valid_i && (next_target == MMR_TGT_NONE);
    // fetches into peripheral space abort even at a populated slot
    next_pabort = req_valid_i && req_fetch_i && (next_abort || is_periph);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      resp_valid_o     <= 1'b0;
      resp_target_o    <= MMR_TGT_NONE;
      resp_addr_o      <= 32'h0000_0000;
      resp_slot_o      <= 7'h00;
      abort_o          <= 1'b0;
      prefetch_abort_o <= 1'b0;
      map_mode_o       <= MMR_MODE_BOOT;
      strap_ext_o      <= 1'b0;
    end else begin
      resp_valid_o     <= next_valid;
      resp_target_o    <= next_target;
      resp_addr_o      <= next_addr;
      resp_slot_o      <= next_slot;
      abort_o          <= next_abort;
      prefetch_abort_o <= next_pabort;
      map_mode_o       <= next_mode;
      strap_ext_o      <= next_strap_ext;
    end
  end

endmodule
`default_nettype wire

// ---- dv/mmr_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mmr_core_model (
  // bus request toward the decoder
  input  wire logic        clk_i,
  output var  logic        req_valid_o = 1'b0,
  output var  logic [31:0] req_addr_o = 32'h0,
  output var  logic        req_fetch_o = 1'b0
);
  // whole aligned words only, never a lone byte lane
  task automatic issue(input logic [31:0] a, input logic f);
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_addr_o  <= {a[31:2], 2'h0};
    req_fetch_o <= f;
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    // idle address inverted so a stale value is never mistaken for a request
    req_addr_o  <= ~a;
  endtask
endmodule
`default_nettype wire

// ---- dv/mmr_decoder_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module mmr_decoder_chk
  import mmr_pkg::*;
#(parameter logic [31:0] FLASH_BYTES = 32'h0002_0000) (
  input wire logic                 ref_clk_i,
  input wire logic                 rst_n_i,
  input wire logic [1:0]           boot_select_pins_i,
  input wire logic                 map_wr_i,
  input wire mmr_pkg::mmr_mode_t   map_mode_i,
  input wire logic                 req_valid_i,
  input wire logic [31:0]          req_addr_i,
  input wire logic                 req_fetch_i,
  input wire logic                 resp_valid_o,
  input wire mmr_pkg::mmr_target_t resp_target_o,
  input wire logic [31:0]          resp_addr_o,
  input wire logic [6:0]           resp_slot_o,
  input wire logic                 abort_o,
  input wire logic                 prefetch_abort_o,
  input wire mmr_pkg::mmr_mode_t   map_mode_o,
  input wire logic                 strap_ext_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire per = req_addr_i[31:21] == MMR_PERIPH_BUS_TAG || req_addr_i[31:21] == MMR_SYS_PERIPH_TAG;
  wire low = req_valid_i && req_addr_i[31:6] == 26'h0;
  a_reset_boot_mode: assert property ($rose(rst_n_i) |-> map_mode_o == MMR_MODE_BOOT)
    else $error("mode not boot after reset");
  a_boot_overlay: assert property (low && map_mode_o == MMR_MODE_BOOT |=>
    resp_target_o == MMR_TGT_BOOT && resp_addr_o == (MMR_BOOT_BASE | $past(req_addr_i))) else $error("boot overlay");
  a_ram_overlay: assert property (low && map_mode_o == MMR_MODE_RAM |=>
    resp_target_o == MMR_TGT_SRAM && resp_addr_o == (MMR_SRAM_BASE | $past(req_addr_i))) else $error("ram overlay");
  a_flash_low_area: assert property (low && map_mode_o == MMR_MODE_FLASH |=>
    resp_target_o == MMR_TGT_FLASH && resp_addr_o == $past(req_addr_i)) else $error("flash low area");
  a_slot_from_addr: assert property (req_valid_i && per |=> resp_slot_o == $past(req_addr_i[20:14]))
    else $error("slot index");
  a_fetch_periph_abort: assert property (req_valid_i && req_fetch_i && per |=> prefetch_abort_o)
    else $error("fetch into peripheral area");
  a_fixed_natural_map: assert property (req_valid_i && !per && !low |=> abort_o || resp_addr_o == $past(req_addr_i))
    else $error("fixed region moved");
  a_mode_write_next: assert property (map_wr_i && map_mode_i != MMR_MODE_EXT |=> map_mode_o == $past(map_mode_i))
    else $error("mode write");
  a_unassigned_abort: assert property (req_valid_i && req_addr_i >= FLASH_BYTES && req_addr_i < MMR_SRAM_BASE |=> abort_o)
    else $error("unassigned region");
  c_ram_overlay: cover property (low && map_mode_o == MMR_MODE_RAM);
  c_fetch_periph: cover property (req_valid_i && req_fetch_i && per);
  c_ext_write: cover property (map_wr_i && map_mode_i == MMR_MODE_EXT && strap_ext_o);
endmodule
`default_nettype wire

// ---- dv/test_memory_map_vector_remap.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_memory_map_vector_remap;
  import mmr_pkg::*;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, map_wr_i = 1'b0, req_valid_i, req_fetch_i;
  logic [1:0] boot_select_pins_i = 2'h3;
  logic [31:0] req_addr_i, resp_addr_o;
  logic [6:0] resp_slot_o;
  logic resp_valid_o, abort_o, prefetch_abort_o, strap_ext_o;
  mmr_mode_t map_mode_i = MMR_MODE_BOOT, map_mode_o;
  mmr_target_t resp_target_o;
  int failures = 0, num_checks = 0, cycles = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  mmr_core_model core_u (.clk_i(ref_clk_i), .req_valid_o(req_valid_i), .req_addr_o(req_addr_i), .req_fetch_o(req_fetch_i));
  mmr_decoder dut_u (.*);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // abort pair given as {prefetch, data}
  task automatic acc(input logic [31:0] a, input logic f, input mmr_target_t t, input logic [31:0] ea, input logic [1:0] ab);
    core_u.issue(a, f);
    #1;
    chk("target", 32'(resp_target_o), 32'(t));
    chk("addr", resp_addr_o, ea);
    chk("aborts", {30'h0, prefetch_abort_o, abort_o}, {30'h0, ab});
    chk("valid", {31'h0, resp_valid_o}, 32'h1);
    // slot index only inside the two peripheral windows
    chk("slot", {25'h0, resp_slot_o},
        (a[31:21] == MMR_PERIPH_BUS_TAG || a[31:21] == MMR_SYS_PERIPH_TAG) ? {25'h0, a[20:14]} : 32'h0);
  endtask
  task automatic wr(input mmr_mode_t m);
    @(posedge ref_clk_i);
    map_wr_i <= 1'b1;
    map_mode_i <= m;
    @(posedge ref_clk_i);
    map_wr_i <= 1'b0;
  endtask
  task automatic do_reset(input logic [1:0] p);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    boot_select_pins_i <= p;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("mode", 32'(map_mode_o), 32'(MMR_MODE_BOOT));
    chk("strap", {31'h0, strap_ext_o}, {31'h0, p != 2'h3});
  endtask
  task automatic s_boot();
    acc(32'h14, 1'b0, MMR_TGT_BOOT, 32'h7FFF_E014, 2'h0);
    acc(32'h3C, 1'b1, MMR_TGT_BOOT, 32'h7FFF_E03C, 2'h0);
    acc(32'h40, 1'b0, MMR_TGT_FLASH, 32'h40, 2'h0);
    acc(32'h7FFF_E01C, 1'b1, MMR_TGT_BOOT, 32'h7FFF_E01C, 2'h0);
  endtask
  task automatic s_modes();
    wr(MMR_MODE_FLASH);
    acc(32'h1C, 1'b1, MMR_TGT_FLASH, 32'h1C, 2'h0);
    // same-cycle request must still see the old mode
    fork
      wr(MMR_MODE_RAM);
      acc(32'h18, 1'b0, MMR_TGT_FLASH, 32'h18, 2'h0);
    join
    acc(32'h18, 1'b0, MMR_TGT_SRAM, 32'h4000_0018, 2'h0);
    wr(MMR_MODE_EXT);
    // look after the write edge has settled the mode flop
    #1;
    chk("refused", 32'(map_mode_o), 32'(MMR_MODE_RAM));
    do_reset(2'h1);
    wr(MMR_MODE_EXT);
    #1;
    chk("accepted", 32'(map_mode_o), 32'(MMR_MODE_EXT));
    acc(32'h4, 1'b0, MMR_TGT_EXT, 32'h8000_0004, 2'h0);
    acc(32'h4000_0010, 1'b0, MMR_TGT_SRAM, 32'h4000_0010, 2'h0);
  endtask
  task automatic s_periph();
    acc(32'hE002_8004, 1'b0, MMR_TGT_PERIPH_BUS, 32'hE002_8004, 2'h0);
    acc(32'hE01F_C040, 1'b1, MMR_TGT_PERIPH_BUS, 32'hE01F_C040, 2'h2);
    acc(32'hE001_C000, 1'b0, MMR_TGT_NONE, 32'hE001_C000, 2'h1);
    acc(32'hFFE0_0008, 1'b0, MMR_TGT_SYS_PERIPH, 32'hFFE0_0008, 2'h0);
    acc(32'h0002_0000, 1'b1, MMR_TGT_NONE, 32'h0002_0000, 2'h3);
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    do_reset(2'h3);
    s_boot();
    s_modes();
    s_periph();
    test_done();
  end
endmodule
bind mmr_decoder mmr_decoder_chk #(.FLASH_BYTES(FLASH_BYTES)) chk_u (.*);
`default_nettype wire
